// ### i2cbr_map.svh
`ifndef I2CBR_MAP_SVH
`define I2CBR_MAP_SVH
// ==========================================================
// Register offsets (byte addresses)
`define I2CBR_OFF_CTRL 8'h00
`define I2CBR_OFF_STAT 8'h04
`define I2CBR_OFF_IRQS 8'h08
`define I2CBR_OFF_IRQM 8'h0C
// ==========================================================
// Control bit positions
`define I2CBR_CTRL_ACK 2
`define I2CBR_CTRL_SI 3
`define I2CBR_CTRL_STO 4
`define I2CBR_CTRL_STA 5
`define I2CBR_CTRL_EN 6
// ==========================================================
// Status codes
`define I2CBR_ST_BERR 8'h00
`define I2CBR_ST_START 8'h08
`define I2CBR_ST_AL_ADDR 8'h38
`define I2CBR_ST_AL_RX 8'h68
`define I2CBR_ST_AL_GC 8'h78
`define I2CBR_ST_AL_SLR 8'hB0
`define I2CBR_ST_NONE 8'hF8
// ==========================================================
// Reset values and timing
`define I2CBR_CTRL_RST 8'h00
`define I2CBR_CLK_MHZ 50
`define I2CBR_HALF_NS 1250
`define I2CBR_HALF_CYC ((`I2CBR_HALF_NS * `I2CBR_CLK_MHZ) / 1000)
`endif

// ### i2cbr_pkg.sv
package i2cbr_pkg;
    // Synchronised two-wire line levels
    typedef struct packed {
        logic scl;
        logic sda;
    } i2cbr_lines_t;
    // Arbitration loss phases reported by the transfer engine
    typedef enum logic [1:0] {
        I2CBR_AL_ADDR,
        I2CBR_AL_RX,
        I2CBR_AL_GC,
        I2CBR_AL_SLR
    } i2cbr_alphase_t;
    typedef enum {
        I2CBR_IDLE,
        I2CBR_WAIT_FREE,
        I2CBR_START_A,
        I2CBR_START_B,
        I2CBR_PULSE_LO,
        I2CBR_PULSE_HI,
        I2CBR_ACTIVE
    } i2cbr_state_t;
endpackage

// ### i2cbr_recovery.sv
`timescale 1ns/1ps
`include "i2cbr_map.svh"
// Operation
// - Yield on foreign repeated START, no interrupt
// - After STOP, retry with normal START
// - Arbitration loss reports one of four codes
// - Start request waits for free bus
// - Forced access: no STOP, bus free, self-clear
// - Held-low clock line stalls the START sequence
// - Held-low data line: send extra clocks
// - Retry START after each two pulses
// - Data released: START and code 08H
// - Same recovery for forced or repeated START
// - START or STOP mid-frame is bus error
// - Bus error only matters when involved
// - Bus error: unaddressed, release, flag, 00H
// - Undefined internal state reports 00H
// - Flag clear reads F8H
// - Stop request clears bus error silently
// - Ack enable gates address recognition
module i2cbr_recovery
    import i2cbr_pkg::*;
#(
    parameter int HALF_CYC = `I2CBR_HALF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe_n_out,
    output logic sda_oe_n_out,
    input wire logic xfer_active_in,
    input wire logic addr_slave_in,
    input wire logic want_rep_start_in,
    input wire logic arb_lost_in,
    input wire i2cbr_alphase_t arb_phase_in,
    input wire logic addr_match_in,
    input wire logic gcall_match_in,
    output logic addressed_out,
    output logic bus_busy_out,
    output logic start_done_out,
    output logic irq_out
);
    initial begin
        if (HALF_CYC < 2) $error("HALF_CYC too small");
    end
    // ==========================================================
    // Line synchronisers
    i2cbr_lines_t sync1_ff, sync2_ff, prev_ff;
    always_ff @(posedge clk_in) begin
        sync1_ff <= '{scl: scl_in, sda: sda_in};
        sync2_ff <= sync1_ff;
        prev_ff <= sync2_ff;
    end
    // ==========================================================
    // Bus condition detection
    wire start_seen = prev_ff.scl && sync2_ff.scl && prev_ff.sda
        && !sync2_ff.sda;
    wire stop_seen = prev_ff.scl && sync2_ff.scl && !prev_ff.sda
        && sync2_ff.sda;
    wire scl_rise = !prev_ff.scl && sync2_ff.scl;
    // ==========================================================
    // Registers
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] stat_ff, nxt_stat;
    logic [3:0] irqs_ff, irqm_ff;
    logic busy_ff, addressed_ff, yield_ff;
    logic [1:0] bitcnt_ff;
    logic [3:0] bitpos_ff;
    logic [15:0] div_ff;
    logic [1:0] pulses_ff;
    logic scl_drv_ff, sda_drv_ff, start_done_ff;
    i2cbr_state_t state_ff, nxt_state;
    wire start_request = ctrl_ff[`I2CBR_CTRL_STA];
    wire stop_request = ctrl_ff[`I2CBR_CTRL_STO];
    wire si = ctrl_ff[`I2CBR_CTRL_SI];
    wire ack_en = ctrl_ff[`I2CBR_CTRL_ACK];
    // ==========================================================
    // APB decode
    wire apb_acc = psel_in && penable_in;
    wire apb_wr = apb_acc && pwrite_in;
    wire wr_ctrl = apb_wr && paddr_in == `I2CBR_OFF_CTRL;
    wire wr_irqs = apb_wr && paddr_in == `I2CBR_OFF_IRQS;
    wire wr_irqm = apb_wr && paddr_in == `I2CBR_OFF_IRQM;
    wire addr_ok = paddr_in == `I2CBR_OFF_CTRL
        || paddr_in == `I2CBR_OFF_STAT || paddr_in == `I2CBR_OFF_IRQS
        || paddr_in == `I2CBR_OFF_IRQM;
    wire [7:0] rd_stat = si ? stat_ff : `I2CBR_ST_NONE;
    wire [31:0] rd_mux =
        paddr_in == `I2CBR_OFF_CTRL ? {24'h000000, ctrl_ff} :
        paddr_in == `I2CBR_OFF_STAT ? {24'h000000, rd_stat} :
        paddr_in == `I2CBR_OFF_IRQS ? {28'h0000000, irqs_ff} :
        paddr_in == `I2CBR_OFF_IRQM ? {28'h0000000, irqm_ff} :
        32'h00000000;
    // ==========================================================
    // Events
    wire involved = xfer_active_in || addressed_ff;
    wire frame_bad = (start_seen || stop_seen) && bitpos_ff != 4'h0;
    wire bus_err = frame_bad && involved && !yield_ff;
    wire undef_st = state_ff == I2CBR_ACTIVE && !xfer_active_in
        && !busy_ff;
    wire err_now = bus_err || undef_st;
    wire forced = start_request && stop_request && busy_ff;
    // Software clears the flag in the same write, so do not need it here
    wire recov = stop_request && stat_ff == `I2CBR_ST_BERR;
    wire foreign_rs = start_seen && busy_ff && xfer_active_in
        && want_rep_start_in && state_ff == I2CBR_ACTIVE;
    wire al_evt = arb_lost_in && !si;
    wire start_ok = state_ff == I2CBR_START_B;
    wire [7:0] al_code =
        arb_phase_in == I2CBR_AL_ADDR ? `I2CBR_ST_AL_ADDR :
        arb_phase_in == I2CBR_AL_RX ? `I2CBR_ST_AL_RX :
        arb_phase_in == I2CBR_AL_GC ? `I2CBR_ST_AL_GC :
        `I2CBR_ST_AL_SLR;
    wire [3:0] evt = {start_ok, al_evt, err_now, 1'b0};
    wire half_tick = div_ff == 16'(HALF_CYC - 1);
    // ==========================================================
    // Bit position tracking inside a frame
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || start_seen || stop_seen) begin
            bitpos_ff <= 4'h0;
        end else if (scl_rise) begin
            bitpos_ff <= bitpos_ff == 4'h8 ? 4'h0 : bitpos_ff + 4'h1;
        end
    end
    // ==========================================================
    // Recovery sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            I2CBR_IDLE: begin
                if (start_request && !si && !yield_ff) begin
                    nxt_state = I2CBR_WAIT_FREE;
                end
            end
            I2CBR_WAIT_FREE: begin
                if (!sync2_ff.scl) begin
                    nxt_state = I2CBR_WAIT_FREE;
                end else if (!busy_ff || forced) begin
                    nxt_state = sync2_ff.sda ? I2CBR_START_A
                        : I2CBR_PULSE_LO;
                end
            end
            I2CBR_START_A: begin
                if (half_tick) begin
                    nxt_state = I2CBR_START_B;
                end
            end
            I2CBR_START_B: nxt_state = I2CBR_ACTIVE;
            I2CBR_PULSE_LO: begin
                if (half_tick) begin
                    nxt_state = I2CBR_PULSE_HI;
                end
            end
            I2CBR_PULSE_HI: begin
                if (half_tick && sync2_ff.scl) begin
                    if (pulses_ff == 2'd1) begin
                        nxt_state = I2CBR_WAIT_FREE;
                    end else begin
                        nxt_state = I2CBR_PULSE_LO;
                    end
                end
            end
            I2CBR_ACTIVE: begin
                if (err_now || foreign_rs || !xfer_active_in) begin
                    nxt_state = I2CBR_IDLE;
                end
            end
            default: nxt_state = I2CBR_IDLE;
        endcase
    end
    // ==========================================================
    // Control and status next values
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_stat = stat_ff;
        if (wr_ctrl) begin
            nxt_ctrl = pwdata_in[7:0];
        end
        if (forced || recov) begin
            nxt_ctrl[`I2CBR_CTRL_STO] = 1'b0;
        end
        if (start_ok) begin
            nxt_ctrl[`I2CBR_CTRL_STA] = 1'b0;
            nxt_ctrl[`I2CBR_CTRL_SI] = 1'b1;
            nxt_stat = `I2CBR_ST_START;
        end
        if (al_evt) begin
            nxt_ctrl[`I2CBR_CTRL_SI] = 1'b1;
            nxt_stat = al_code;
        end
        if (err_now) begin
            nxt_ctrl[`I2CBR_CTRL_SI] = 1'b1;
            nxt_stat = `I2CBR_ST_BERR;
        end
    end
    // ==========================================================
    // Register updates
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_ff <= `I2CBR_CTRL_RST;
            stat_ff <= `I2CBR_ST_NONE;
            irqs_ff <= 4'h0;
            irqm_ff <= 4'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            stat_ff <= nxt_stat;
            irqs_ff <= (irqs_ff & ~(wr_irqs ? pwdata_in[3:0] : 4'h0))
                | evt;
            irqm_ff <= wr_irqm ? pwdata_in[3:0] : irqm_ff;
        end
    end
    // ==========================================================
    // Busy, yield and addressed tracking
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            busy_ff <= 1'b0;
            yield_ff <= 1'b0;
            addressed_ff <= 1'b0;
        end else begin
            if (start_seen) begin
                busy_ff <= 1'b1;
            end else if (stop_seen || forced || recov) begin
                busy_ff <= 1'b0;
            end
            if (foreign_rs) begin
                yield_ff <= 1'b1;
            end else if (stop_seen || forced) begin
                yield_ff <= 1'b0;
            end
            if (err_now || recov || stop_seen) begin
                addressed_ff <= 1'b0;
            end else if (addr_slave_in && ack_en
                && (addr_match_in || gcall_match_in)) begin
                addressed_ff <= 1'b1;
            end
        end
    end
    // ==========================================================
    // Sequencer, divider and line drive
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= I2CBR_IDLE;
            div_ff <= 16'h0000;
            pulses_ff <= 2'd0;
            scl_drv_ff <= 1'b0;
            sda_drv_ff <= 1'b0;
            start_done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            div_ff <= (half_tick || nxt_state != state_ff) ? 16'h0000
                : div_ff + 16'h0001;
            if (state_ff == I2CBR_PULSE_HI && nxt_state != state_ff) begin
                pulses_ff <= pulses_ff + 2'd1;
            end else if (state_ff == I2CBR_WAIT_FREE) begin
                pulses_ff <= 2'd0;
            end
            scl_drv_ff <= nxt_state == I2CBR_PULSE_LO;
            sda_drv_ff <= nxt_state == I2CBR_START_A
                || nxt_state == I2CBR_START_B;
            start_done_ff <= start_ok;
        end
    end
    // ==========================================================
    // APB answer and outputs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            irq_out <= 1'b0;
            addressed_out <= 1'b0;
            bus_busy_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !addr_ok;
            prdata_out <= rd_mux;
            irq_out <= |(irqs_ff & irqm_ff);
            addressed_out <= addressed_ff;
            bus_busy_out <= busy_ff;
        end
    end
    assign scl_oe_n_out = !scl_drv_ff;
    assign sda_oe_n_out = !sda_drv_ff;
    assign start_done_out = start_done_ff;
    // ==========================================================
    // Checks
    a_flag_clear_code: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) !si |-> rd_stat == `I2CBR_ST_NONE)
        else $error("status not F8 while flag clear");
    a_berr_sets_code: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) err_now |=> si
        && stat_ff == `I2CBR_ST_BERR && !addressed_ff)
        else $error("bus error not reported");
    a_forced_clears_sto: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) forced && !wr_ctrl |=> !stop_request && !busy_ff)
        else $error("forced access not handled");
    a_start_code: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) start_ok && !err_now && !al_evt
        |=> stat_ff == `I2CBR_ST_START && si)
        else $error("start code missing");
    a_yield_release: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) foreign_rs |=> ##1 sda_oe_n_out)
        else $error("bus not released on yield");
    a_idle_ignore: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) frame_bad && !involved |=> !$rose(si)
        || stat_ff != `I2CBR_ST_BERR)
        else $error("error flagged while uninvolved");
    a_recov_sto: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) recov && !wr_ctrl |=> !stop_request && !busy_ff)
        else $error("bus error recovery failed");
    a_pulse_drive: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) state_ff == I2CBR_PULSE_LO
        |-> !scl_oe_n_out && sda_oe_n_out)
        else $error("recovery pulse drive wrong");
endmodule

// ### i2cbr_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Far-side two-wire party: foreign master or slave out of step
module i2cbr_partner (
    output logic scl_oe_n_out,
    output logic sda_oe_n_out
);
    // Idle released, lines sit at the pull-up level
    initial begin
        scl_oe_n_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end
    // One half period of the 160 ns link clock per step
    task automatic step(input logic s, input logic d);
        scl_oe_n_out = s;
        sda_oe_n_out = d;
        #80;
    endtask
endmodule

// ### i2c_bus_recovery_handling_test.sv
`timescale 1ns/1ps
module i2c_bus_recovery_handling_test;
    import i2cbr_pkg::*;
    // ======================================================
    // Stimulus and observed signals
    typedef struct {logic [31:0] d; logic e; string n;} i2cbr_exp_t;
    logic clk_in = 1'b0, rst_n_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic xfer = 1'b0, aslv = 1'b0, wrep = 1'b0, arb = 1'b0;
    logic amatch = 1'b0, gmatch = 1'b0, hit;
    i2cbr_alphase_t aph = I2CBR_AL_ADDR;
    logic pready, pslverr, d_scl_n, d_sda_n, p_scl_n, p_sda_n;
    logic addressed, busy, sdone, irq;
    logic [7:0] ac [4] = '{8'h38, 8'h68, 8'h78, 8'hB0};
    int errors = 0, tests_run = 0, pulses = 0;
    i2cbr_exp_t exp_q [$];
    // Wired-AND lines with pull-ups
    wire scl = d_scl_n & p_scl_n;
    wire sda = d_sda_n & p_sda_n;

    always #10 clk_in = ~clk_in;
    // Count clock pulses the block drives itself
    always @(negedge d_scl_n) pulses++;

    i2cbr_recovery #(.HALF_CYC(4)) u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .scl_in(scl), .sda_in(sda),
        .scl_oe_n_out(d_scl_n), .sda_oe_n_out(d_sda_n),
        .xfer_active_in(xfer), .addr_slave_in(aslv),
        .want_rep_start_in(wrep), .arb_lost_in(arb),
        .arb_phase_in(aph), .addr_match_in(amatch),
        .gcall_match_in(gmatch), .addressed_out(addressed),
        .bus_busy_out(busy), .start_done_out(sdone), .irq_out(irq)
    );
    i2cbr_partner u_peer (.scl_oe_n_out(p_scl_n), .sda_oe_n_out(p_sda_n));

    // ======================================================
    // Checking helpers
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Read monitor: oldest note against each completed read
    always @(posedge clk_in) begin : mon
        i2cbr_exp_t x;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            x = exp_q.pop_front();
            chk(x.n, x.d, prdata);
            chk({x.n, " slverr"}, {31'h0, x.e}, {31'h0, pslverr});
        end
    end
    // APB master, holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        k = 0;
        @(posedge clk_in);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge clk_in);
            k++;
        end
        if (k >= 50) errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        exp_q.push_back('{e, a > 8'h0C, n});
        apb(1'b0, a, 32'h0);
    endtask
    // Bounded wait for a START-sent pulse
    task automatic wt(input int lim, output logic h);
        int k;
        k = 0;
        while (sdone !== 1'b1 && k < lim) begin
            @(posedge clk_in);
            k++;
        end
        h = (sdone === 1'b1);
    endtask
    // Far-side line steps, two bits per step, oldest first
    task automatic pseq(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) u_peer.step(v[2*i+1], v[2*i]);
    endtask
    task automatic irqchk(input logic e, input string n);
        repeat (3) @(posedge clk_in);
        chk(n, {31'h0, e}, {31'h0, irq});
    endtask
    task automatic clr;
        apb(1'b1, 8'h00, 32'h40);
        apb(1'b1, 8'h08, 32'h0E);
    endtask
    task end_sim;
        $display("Checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #500000;
        errors++;
        end_sim;
    end

    // ======================================================
    // Main sequence
    initial begin
        void'($urandom(32'h3D75A570));
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(8'h00, 32'h0, "ctrl reset");
        rd(8'h04, 32'hF8, "status reset");
        rd(8'h10, 32'h0, "unmapped");
        // Plain START, interrupt masked then unmasked then cleared
        apb(1'b1, 8'h00, 32'h60);
        wt(200, hit);
        chk("free start", 1, hit);
        rd(8'h04, 32'h08, "status start");
        rd(8'h08, 32'h08, "irq status start");
        irqchk(1'b0, "irq masked");
        apb(1'b1, 8'h0C, 32'h0E);
        irqchk(1'b1, "irq raised");
        clr;
        irqchk(1'b0, "irq cleared");
        rd(8'h04, 32'hF8, "status idle");
        // Arbitration loss codes, all four phases
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            xfer <= 1'b1;
            arb <= 1'b1;
            aph <= i2cbr_alphase_t'(i);
            @(posedge clk_in);
            arb <= 1'b0;
            xfer <= 1'b0;
            repeat ($urandom_range(2, 9)) @(posedge clk_in);
            rd(8'h04, {24'h0, ac[i]}, "arb code");
            clr;
        end
        // Held-low data line: extra clocks then START
        pseq(32'h12, 3);
        pulses = 0;
        apb(1'b1, 8'h00, 32'h60);
        repeat ($urandom_range(60, 150)) @(posedge clk_in);
        pseq(32'h3, 1);
        wt(400, hit);
        chk("recovered start", 1, hit);
        chk("extra pulses", 1, pulses >= 2);
        chk("pulse pairs", 0, pulses % 2);
        rd(8'h04, 32'h08, "status recovered");
        clr;
        // Bus left busy, then forced access
        pseq(32'h387, 5);
        chk("busy", 1, busy);
        apb(1'b1, 8'h00, 32'h60);
        wt(40, hit);
        chk("waits while busy", 0, hit);
        apb(1'b1, 8'h00, 32'h70);
        wt(200, hit);
        chk("forced start", 1, hit);
        rd(8'h00, 32'h48, "ctrl stop cleared");
        clr;
        // Foreign repeated START: yield, then retry after STOP
        xfer <= 1'b1;
        wrep <= 1'b1;
        apb(1'b1, 8'h00, 32'h60);
        @(negedge d_sda_n);
        repeat (3) @(posedge clk_in);
        u_peer.step(1'b0, 1'b1);
        rd(8'h04, 32'h08, "status own start");
        clr;
        // Nine far-side clocks close the byte, then its repeated START
        pseq(32'h77777777, 16);
        pseq(32'h7, 2);
        pseq(32'h2, 1);
        chk("yield scl", 1, d_scl_n);
        chk("yield sda", 1, d_sda_n);
        chk("yield no irq", 0, irq);
        rd(8'h04, 32'hF8, "status yield");
        apb(1'b1, 8'h00, 32'h60);
        pseq(32'h4B, 4);
        wt(200, hit);
        chk("retry start", 1, hit);
        rd(8'h04, 32'h08, "status retry");
        xfer <= 1'b0;
        wrep <= 1'b0;
        clr;
        // Mid-byte STOP while not involved is ignored
        pseq(32'h38774B, 11);
        rd(8'h04, 32'hF8, "status ignored");
        // Address recognition gated by ack_enable
        aslv <= 1'b1;
        amatch <= 1'b1;
        gmatch <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("ack off", 0, addressed);
        apb(1'b1, 8'h00, 32'h44);
        gmatch <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk("ack on", 1, addressed);
        aslv <= 1'b0;
        amatch <= 1'b0;
        // Mid-byte STOP while involved is a bus error
        xfer <= 1'b1;
        pseq(32'h38774B, 11);
        rd(8'h04, 32'h00, "status bus error");
        rd(8'h08, 32'h02, "irq status error");
        chk("unaddressed", 0, addressed);
        chk("error scl", 1, d_scl_n);
        chk("error sda", 1, d_sda_n);
        xfer <= 1'b0;
        apb(1'b1, 8'h00, 32'h54);
        rd(8'h00, 32'h44, "ctrl after recovery");
        rd(8'h04, 32'hF8, "status after recovery");
        chk("bus free", 0, busy);
        end_sim;
    end
endmodule
